/* interval_timer_pair.sv */
// top: apb register file and interrupt routing for the interval timer pair
// ==================================================
// Summary of operation
// - counter equals compare sets compare flag
// - overflow in capture modes sets same flag
// - measure flag gated by channel enable only
// - compare irq needs both enable bits
// - wide mode silences upper channel sources
// - lower irq is request 5, upper 6
// - mode bits select one-shot/continuous/free-run
// - start counts from zero on count edge
// - one-shot match: toggle, flag, clear run, halt
// - one-shot latches compare only at start
// - continuous match: toggle, flag, restart zero
// - continuous/free-run reload latch at match
// - stopped timer keeps output bit level until a pair mode write loads it
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module interval_timer_pair (
  input  wire logic        ref_clk_i,     // 125 MHz system clock
  input  wire logic        rst_b_i,       // sync reset, active low
  input  wire logic        clk_en_i,      // freezes all state when low
  input  wire logic        psel_i,        // apb select
  input  wire logic        penable_i,     // apb enable
  input  wire logic        pwrite_i,      // apb direction
  input  wire logic [7:0]  paddr_i,       // apb byte address
  input  wire logic [31:0] pwdata_i,      // apb write data
  input  wire logic [3:0]  pstrb_i,       // apb byte strobes
  output logic [31:0]      prdata_o,      // apb read data
  output logic             pready_o,      // apb ready
  output logic             pslverr_o,     // apb error on unmapped address
  input  wire logic        meas_lower_i,  // lower capture/measure event, same clock
  input  wire logic        meas_upper_i,  // upper capture/measure event, same clock
  output logic             irq5_o,        // lower channel interrupt request
  output logic             irq6_o,        // upper channel interrupt request
  output logic             lower_out_o,   // lower timer output level
  output logic             upper_out_o    // upper timer output level
);

  // ==================================================
  // registers
  logic [7:0] ctl0 [timer_pkg::NUM_CHAN];
  logic [7:0] ctl1 [timer_pkg::NUM_CHAN];
  logic [7:0] cdata [timer_pkg::NUM_CHAN];
  logic [7:0] count [timer_pkg::NUM_CHAN];
  logic       out_bit [timer_pkg::NUM_CHAN];
  logic       wide_mode_bit;
  logic [7:0] clk_div;

  timer_pkg::chan_ctrl_t ctrl [timer_pkg::NUM_CHAN];
  timer_pkg::chan_evt_t  evt  [timer_pkg::NUM_CHAN];
  logic                  meas [timer_pkg::NUM_CHAN];
  logic                  tick;
  logic                  wr;
  logic                  rd_hit;
  logic [7:0]            next_rdata;
  logic                  mapped;

  assign meas[0] = meas_lower_i;
  assign meas[1] = meas_upper_i;

  // ==================================================
  // apb: zero wait states
  assign pready_o = 1'b1;
  assign wr       = psel_i && penable_i && pwrite_i && pstrb_i[0] && clk_en_i;
  assign rd_hit   = psel_i && !penable_i && !pwrite_i;

  always_comb begin
    next_rdata = timer_pkg::REG_RESET;
    mapped     = 1'b1;
    if (paddr_i == timer_pkg::OFS_LOWER_CONTROL_0) begin
      next_rdata = ctl0[0];
    end else if (paddr_i == timer_pkg::OFS_LOWER_CONTROL_1) begin
      next_rdata = ctl1[0];
    end else if (paddr_i == timer_pkg::OFS_LOWER_DATA) begin
      next_rdata = count[0];
    end else if (paddr_i == timer_pkg::OFS_UPPER_CONTROL_0) begin
      next_rdata = ctl0[1];
    end else if (paddr_i == timer_pkg::OFS_UPPER_CONTROL_1) begin
      next_rdata = ctl1[1];
    end else if (paddr_i == timer_pkg::OFS_UPPER_DATA) begin
      next_rdata = count[1];
    end else if (paddr_i == timer_pkg::OFS_PAIR_MODE) begin
      next_rdata = {out_bit[1], out_bit[0], 2'b00, wide_mode_bit, 3'b000};
    end else if (paddr_i == timer_pkg::OFS_COUNT_CLK_DIV) begin
      next_rdata = clk_div;
    end else begin
      mapped = 1'b0;
    end
  end

  assign pslverr_o = psel_i && penable_i && !mapped;

  // read data captured in setup so it comes from a flop during access
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (clk_en_i && rd_hit) begin
      prdata_o <= {24'h00_0000, next_rdata};
    end
  end

  // ==================================================
  // pair mode, divider and count tick
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      wide_mode_bit <= 1'b0;
      clk_div       <= timer_pkg::DIV_RESET;
    end else if (wr && paddr_i == timer_pkg::OFS_PAIR_MODE) begin
      wide_mode_bit <= pwdata_i[timer_pkg::PM_WIDE_POS];
    end else if (wr && paddr_i == timer_pkg::OFS_COUNT_CLK_DIV) begin
      clk_div <= pwdata_i[7:0];
    end
  end

  count_tick_gen u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (clk_en_i),
    .div_i     (clk_div),
    .tick_o    (tick)
  );

  // ==================================================
  // per-channel control, flags and output bit
  for (genvar c = 0; c < timer_pkg::NUM_CHAN; c++) begin : g_ch
    localparam logic [7:0] OFS_C0 = (c == 0) ? timer_pkg::OFS_LOWER_CONTROL_0 : timer_pkg::OFS_UPPER_CONTROL_0;
    localparam logic [7:0] OFS_C1 = (c == 0) ? timer_pkg::OFS_LOWER_CONTROL_1 : timer_pkg::OFS_UPPER_CONTROL_1;
    localparam logic [7:0] OFS_D  = (c == 0) ? timer_pkg::OFS_LOWER_DATA : timer_pkg::OFS_UPPER_DATA;
    localparam int         OUT_P  = (c == 0) ? timer_pkg::PM_LOWER_OUT_POS : timer_pkg::PM_UPPER_OUT_POS;
    logic wr_c1;
    logic busy;
    logic flag_set;
    logic meas_set;
    logic other_mode;
    logic started;
    logic ovf_set;

    assign wr_c1 = wr && paddr_i == OFS_C1;
    assign busy  = ctl1[c][timer_pkg::CR1_RUN_POS];
    // upper channel sources are dead in wide mode
    assign flag_set = evt[c].match && !(c == 1 && wide_mode_bit);
    assign meas_set = meas[c] && clk_en_i && !(c == 1 && wide_mode_bit);
    // codes outside the interval set count like a capture mode; only their wrap is flagged
    assign other_mode = !(ctrl[c].mode == timer_pkg::MODE_ONE_SHOT || ctrl[c].mode == timer_pkg::MODE_CONTINUOUS
                          || ctrl[c].mode == timer_pkg::MODE_FREE_RUN);
    assign ovf_set    = started && busy && tick && (&count[c]) && other_mode
                        && !(c == 1 && wide_mode_bit);

    // mirrors the channel's counting state, so a stale all-ones count before start is no wrap
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
        started <= 1'b0;
      end else if (clk_en_i) begin
        started <= busy && (started || tick);
      end
    end

    assign ctrl[c].run         = busy;
    assign ctrl[c].mode        = ctl0[c][timer_pkg::CR0_MODE_LSB +: timer_pkg::MODE_W];
    assign ctrl[c].irq_en      = ctl1[c][timer_pkg::CR1_IRQ_EN_POS];
    assign ctrl[c].flag_irq_en = ctl0[c][timer_pkg::CR0_FLAG_IRQ_EN_POS];

    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
        ctl0[c] <= timer_pkg::REG_RESET;
      end else if (wr && paddr_i == OFS_C0) begin
        ctl0[c] <= pwdata_i[7:0];
      end
    end

    // zero compare value refused while counting
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
        cdata[c] <= timer_pkg::REG_RESET;
      end else if (wr && paddr_i == OFS_D && !(busy && pwdata_i[7:0] == timer_pkg::COUNT_ZERO)) begin
        cdata[c] <= pwdata_i[7:0];
      end
    end

    // control_1: run bit, enable, flags; hardware set beats software clear
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
        ctl1[c] <= timer_pkg::REG_RESET;
      end else if (clk_en_i) begin
        if (wr_c1) begin
          ctl1[c][timer_pkg::CR1_RUN_POS]    <= pwdata_i[timer_pkg::CR1_RUN_POS];
          ctl1[c][timer_pkg::CR1_IRQ_EN_POS] <= pwdata_i[timer_pkg::CR1_IRQ_EN_POS];
          // flags only clear by writing zero
          if (!pwdata_i[timer_pkg::CR1_FLAG_POS]) begin
            ctl1[c][timer_pkg::CR1_FLAG_POS] <= 1'b0;
          end
          if (!pwdata_i[timer_pkg::CR1_MEASURE_POS]) begin
            ctl1[c][timer_pkg::CR1_MEASURE_POS] <= 1'b0;
          end
        end
        if (evt[c].stop) begin
          ctl1[c][timer_pkg::CR1_RUN_POS] <= 1'b0;
        end
        if (flag_set || ovf_set) begin
          ctl1[c][timer_pkg::CR1_FLAG_POS] <= 1'b1;
        end
        if (meas_set) begin
          ctl1[c][timer_pkg::CR1_MEASURE_POS] <= 1'b1;
        end
      end
    end

    // output bit toggles on match; while stopped it holds or loads from a pair mode write
    always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
        out_bit[c] <= 1'b0;
      end else if (clk_en_i) begin
        if (evt[c].match) begin
          out_bit[c] <= !out_bit[c];
        end else if (wr && paddr_i == timer_pkg::OFS_PAIR_MODE && !busy) begin
          out_bit[c] <= pwdata_i[OUT_P];
        end
      end
    end

    timer_channel u_chan (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .ce_i      (clk_en_i),
      .tick_i    (tick),
      .ctrl_i    (ctrl[c]),
      .data_i    (cdata[c]),
      .count_o   (count[c]),
      .evt_o     (evt[c])
    );
  end

  // ==================================================
  // interrupt requests, level while an enabled flag stands
  assign irq5_o = ctrl[0].irq_en && ((ctrl[0].flag_irq_en && ctl1[0][timer_pkg::CR1_FLAG_POS])
                  || ctl1[0][timer_pkg::CR1_MEASURE_POS]);
  assign irq6_o = !wide_mode_bit && ctrl[1].irq_en
                  && ((ctrl[1].flag_irq_en && ctl1[1][timer_pkg::CR1_FLAG_POS])
                  || ctl1[1][timer_pkg::CR1_MEASURE_POS]);

  assign lower_out_o = out_bit[0];
  assign upper_out_o = out_bit[1];

endmodule
`default_nettype wire

/* timer_pkg.sv */
// package: register map, field positions and types for the composite timer pair
package timer_pkg;

  // ==================================================
  // register byte offsets (apb, one aligned word each)
  localparam logic [7:0] OFS_LOWER_CONTROL_0  = 8'h00;
  localparam logic [7:0] OFS_LOWER_CONTROL_1  = 8'h04;
  localparam logic [7:0] OFS_LOWER_DATA       = 8'h08;
  localparam logic [7:0] OFS_UPPER_CONTROL_0  = 8'h0c;
  localparam logic [7:0] OFS_UPPER_CONTROL_1  = 8'h10;
  localparam logic [7:0] OFS_UPPER_DATA       = 8'h14;
  localparam logic [7:0] OFS_PAIR_MODE        = 8'h18;
  localparam logic [7:0] OFS_COUNT_CLK_DIV    = 8'h1c;

  // ==================================================
  // control_0 fields
  localparam int CR0_FLAG_IRQ_EN_POS = 7;
  localparam int CR0_MODE_LSB        = 0;
  localparam int MODE_W              = 4;
  // control_1 fields
  localparam int CR1_RUN_POS         = 7;
  localparam int CR1_IRQ_EN_POS      = 5;
  localparam int CR1_MEASURE_POS     = 4;
  localparam int CR1_FLAG_POS        = 2;
  // pair mode fields
  localparam int PM_UPPER_OUT_POS    = 7;
  localparam int PM_LOWER_OUT_POS    = 6;
  localparam int PM_WIDE_POS         = 4;

  // ==================================================
  // operating-mode encodings
  localparam logic [3:0] MODE_ONE_SHOT   = 4'h0;
  localparam logic [3:0] MODE_CONTINUOUS = 4'h1;
  localparam logic [3:0] MODE_FREE_RUN   = 4'h2;

  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] COUNT_ZERO  = 8'h00;
  localparam logic [7:0] COUNT_ONE   = 8'h01;
  localparam logic [7:0] DIV_RESET   = 8'h00;
  localparam int         NUM_CHAN    = 2;

  // channel control carried as one bundle
  typedef struct packed {
    logic       run;
    logic [3:0] mode;
    logic       irq_en;
    logic       flag_irq_en;
  } chan_ctrl_t;

  // event reported by a channel, one-cycle pulses
  typedef struct packed {
    logic match;
    logic stop;
  } chan_evt_t;

  typedef enum logic [1:0] {
    CH_IDLE  = 2'b00,
    CH_COUNT = 2'b01
  } chan_state_t;

endpackage

/* count_tick_gen.sv */
// count clock enable divider shared by both channels
`timescale 1ns/1ps
`default_nettype none

module count_tick_gen (
  input  wire logic       ref_clk_i,  // system clock
  input  wire logic       rst_b_i,    // sync reset, active low
  input  wire logic       ce_i,       // clock enable
  input  wire logic [7:0] div_i,      // ticks every div_i+1 clocks
  output logic            tick_o      // count clock edge pulse
);

  logic [7:0] cnt;

  // ==================================================
  // divider
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      cnt <= timer_pkg::COUNT_ZERO;
    end else if (ce_i) begin
      if (cnt >= div_i) begin
        cnt <= timer_pkg::COUNT_ZERO;
      end else begin
        cnt <= cnt + timer_pkg::COUNT_ONE;
      end
    end
  end

  assign tick_o = ce_i && (cnt >= div_i);

endmodule
`default_nettype wire

/* timer_channel.sv */
// one 8-bit interval timer channel: counter, compare latch, match/stop events
`timescale 1ns/1ps
`default_nettype none

module timer_channel (
  input  wire logic                  ref_clk_i,  // system clock
  input  wire logic                  rst_b_i,    // sync reset, active low
  input  wire logic                  ce_i,       // clock enable
  input  wire logic                  tick_i,     // count clock rising edge
  input  wire timer_pkg::chan_ctrl_t ctrl_i,     // run bit and mode
  input  wire logic [7:0]            data_i,     // compare data register
  output logic [7:0]                 count_o,    // counter value
  output timer_pkg::chan_evt_t       evt_o       // match / self-stop pulses
);

  timer_pkg::chan_state_t state;
  logic [7:0]             latch;
  logic                   hit;
  logic                   one_shot;
  logic                   continuous;
  logic                   free_run;

  assign one_shot   = ctrl_i.mode == timer_pkg::MODE_ONE_SHOT;
  assign continuous = ctrl_i.mode == timer_pkg::MODE_CONTINUOUS;
  assign free_run   = ctrl_i.mode == timer_pkg::MODE_FREE_RUN;
  assign hit = (state == timer_pkg::CH_COUNT) && tick_i && ctrl_i.run
               && (count_o + timer_pkg::COUNT_ONE == latch);

  // ==================================================
  // state, counter and compare latch
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state   <= timer_pkg::CH_IDLE;
      count_o <= timer_pkg::COUNT_ZERO;
      latch   <= timer_pkg::REG_RESET;
    end else if (ce_i) begin
      case (state)
        timer_pkg::CH_IDLE: begin
          if (ctrl_i.run && tick_i) begin
            state   <= timer_pkg::CH_COUNT;
            count_o <= timer_pkg::COUNT_ZERO;
            latch   <= data_i;
          end
        end
        default: begin
          if (!ctrl_i.run) begin
            state <= timer_pkg::CH_IDLE;
          end else if (hit && one_shot) begin
            count_o <= count_o + timer_pkg::COUNT_ONE;
            state   <= timer_pkg::CH_IDLE;
          end else if (hit && continuous) begin
            count_o <= timer_pkg::COUNT_ZERO;
            latch   <= data_i;
          end else if (hit && free_run) begin
            count_o <= count_o + timer_pkg::COUNT_ONE;
            latch   <= data_i;
          end else if (tick_i) begin
            // wraps ff -> 00 naturally
            count_o <= count_o + timer_pkg::COUNT_ONE;
          end
        end
      endcase
    end
  end

  // unsupported modes count but never match
  assign evt_o.match = hit && (one_shot || continuous || free_run);
  assign evt_o.stop  = hit && one_shot;

endmodule
`default_nettype wire

/* interval_timer_pair_asserts.sv */
// checker: port-level properties of the interval timer pair
`timescale 1ns/1ps
`default_nettype none

module interval_timer_pair_asserts (
  input wire logic        ref_clk_i,    // system clock
  input wire logic        rst_b_i,      // sync reset, active low
  input wire logic        clk_en_i,     // clock enable
  input wire logic        psel_i,       // apb select
  input wire logic        penable_i,    // apb enable
  input wire logic        pwrite_i,     // apb direction
  input wire logic [7:0]  paddr_i,      // apb address
  input wire logic [31:0] pwdata_i,     // apb write data
  input wire logic [3:0]  pstrb_i,      // apb strobes
  input wire logic [31:0] prdata_o,     // apb read data
  input wire logic        pready_o,     // apb ready
  input wire logic        pslverr_o,    // apb error
  input wire logic        meas_lower_i, // lower measure event
  input wire logic        meas_upper_i, // upper measure event
  input wire logic        irq5_o,       // lower request
  input wire logic        irq6_o,       // upper request
  input wire logic        lower_out_o   // lower output bit
);
  // ==================================================
  // shadow of enable bits, tracked from bus writes only
  logic wr_any;
  logic lo_ie;
  logic up_ie;
  logic wide;
  assign wr_any = psel_i & penable_i & pwrite_i;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      lo_ie <= 1'b0;
      up_ie <= 1'b0;
      wide  <= 1'b0;
    end else if (wr_any && pstrb_i[0] && clk_en_i) begin
      if (paddr_i == timer_pkg::OFS_LOWER_CONTROL_1) lo_ie <= pwdata_i[timer_pkg::CR1_IRQ_EN_POS];
      if (paddr_i == timer_pkg::OFS_UPPER_CONTROL_1) up_ie <= pwdata_i[timer_pkg::CR1_IRQ_EN_POS];
      if (paddr_i == timer_pkg::OFS_PAIR_MODE) wide <= pwdata_i[timer_pkg::PM_WIDE_POS];
    end
  end

  // ==================================================
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_ready_access: assert property (psel_i && penable_i |-> pready_o) else $error("ready low in access");
  a_unmapped_err: assert property (psel_i && penable_i && paddr_i > 8'h1c |-> pslverr_o) else $error("no error");
  a_mapped_ok: assert property (psel_i && penable_i && paddr_i <= 8'h1c && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
    else $error("error on mapped register");
  a_irq_needs_ie: assert property (irq5_o |-> lo_ie) else $error("lower request without enable");
  a_wide_mutes: assert property (wide |-> !irq6_o) else $error("upper request in wide mode");
  a_meas_raises: assert property (meas_lower_i && clk_en_i && lo_ie && !wr_any |=> irq5_o)
    else $error("measure event gave no request");
  a_upper_meas: assert property (meas_upper_i && clk_en_i && up_ie && !wide && !wr_any |=> irq6_o)
    else $error("upper measure event gave no request");
  a_irq_holds: assert property (irq5_o && !wr_any |=> irq5_o) else $error("request dropped on its own");
  a_fall_cause: assert property ($fell(irq5_o) && $past(rst_b_i) |-> $past(wr_any))
    else $error("request fell without a write");
  a_freeze_outs: assert property (!clk_en_i |=> $stable(lower_out_o) && $stable(irq5_o) && $stable(prdata_o))
    else $error("state moved while frozen");
endmodule

bind interval_timer_pair interval_timer_pair_asserts chk_u (.ref_clk_i, .rst_b_i, .clk_en_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .meas_lower_i, .meas_upper_i, .irq5_o,
  .irq6_o, .lower_out_o);
`default_nettype wire

/* tb_top.sv */
// testbench: apb register sequences for the interval timer pair
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [7:0] L0 = timer_pkg::OFS_LOWER_CONTROL_0;
  localparam logic [7:0] L1 = timer_pkg::OFS_LOWER_CONTROL_1;
  localparam logic [7:0] LD = timer_pkg::OFS_LOWER_DATA;
  localparam logic [7:0] U1 = timer_pkg::OFS_UPPER_CONTROL_1;
  localparam logic [7:0] UD = timer_pkg::OFS_UPPER_DATA;
  localparam logic [7:0] PM = timer_pkg::OFS_PAIR_MODE;
  logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, clk_en_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  pstrb_i = 4'hf;
  logic        meas_lower_i = 1'b0, meas_upper_i = 1'b0;
  logic [31:0] prdata_o, d;
  logic        pready_o, pslverr_o, irq5_o, irq6_o, lower_out_o, upper_out_o, err, o;
  int          miscompares = 0, comparisons = 0, n;

  interval_timer_pair dut_u (.ref_clk_i, .rst_b_i, .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .meas_lower_i, .meas_upper_i, .irq5_o, .irq6_o, .lower_out_o,
    .upper_out_o);

  always #4 ref_clk_i = ~ref_clk_i;

  // ==================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    comparisons++;
    if (seen !== expv) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, expv);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // master never assumes a latency: waits for pready, with no limit of its own
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v}, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, d);
  endtask
  task automatic wait_flag();
    for (int i = 0; i < 200; i++) begin
      rd(L1);
      if (d[timer_pkg::CR1_FLAG_POS] === 1'b1) break;
    end
    check({31'h0, d[timer_pkg::CR1_FLAG_POS]}, 32'h1);
  endtask
  task automatic pulse(input logic up);
    @(posedge ref_clk_i);
    meas_lower_i <= !up;
    meas_upper_i <= up;
    @(posedge ref_clk_i);
    meas_lower_i <= 1'b0;
    meas_upper_i <= 1'b0;
    @(negedge ref_clk_i);
  endtask

  initial begin
    repeat (50000) @(posedge ref_clk_i);
    miscompares++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4));
      check(d, 32'h0);
    end
    rd(8'h20);
    check({31'h0, err}, 32'h1);
    // one-shot: late data writes must not move the latch
    wr(LD, 8'h0a);
    wr(L0, 8'h80);
    wr(L1, 8'ha0);
    wr(LD, 8'h03);
    wr(LD, 8'h00);
    wait_flag();
    check(d, 32'h24);
    rd(LD);
    check(d, 32'h0a);
    repeat (20) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({31'h0, lower_out_o}, 32'h1);
    check({31'h0, irq5_o}, 32'h1);
    wr(L0, 8'h00);
    @(negedge ref_clk_i);
    check({31'h0, irq5_o}, 32'h0);
    wr(L0, 8'h80);
    @(negedge ref_clk_i);
    check({31'h0, irq5_o}, 32'h1);
    wr(L1, 8'h20);
    @(negedge ref_clk_i);
    check({31'h0, irq5_o}, 32'h0);
    // continuous: reload of a shorter value at a match
    wr(LD, 8'h04);
    wr(L0, 8'h81);
    wr(L1, 8'ha0);
    wait_flag();
    wr(LD, 8'h02);
    wr(L1, 8'ha0);
    wait_flag();
    wr(L1, 8'ha0);
    wait_flag();
    check({31'h0, d[timer_pkg::CR1_RUN_POS]}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rd(LD);
      check({31'h0, d[7:0] <= 8'h02}, 32'h1);
    end
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    wr(L1, 8'h20);
    @(negedge ref_clk_i);
    o = lower_out_o;
    repeat (30) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({31'h0, lower_out_o}, {31'h0, o});
    // free-run: keeps counting past the match and wraps
    wr(LD, 8'h03);
    wr(L0, 8'h82);
    wr(L1, 8'ha0);
    wait_flag();
    rd(LD);
    check({31'h0, d[7:0] > 8'h03}, 32'h1);
    o = lower_out_o;
    for (n = 0; n < 600 && lower_out_o === o; n++) @(negedge ref_clk_i);
    check({31'h0, n < 600}, 32'h1);
    wr(L1, 8'h00);
    // undefined mode code counts without matching
    wr(L0, 8'h83);
    wr(L1, 8'ha0);
    repeat (60) @(posedge ref_clk_i);
    rd(L1);
    check({31'h0, d[timer_pkg::CR1_FLAG_POS]}, 32'h0);
    repeat (220) @(posedge ref_clk_i);
    rd(L1);
    check({31'h0, d[timer_pkg::CR1_FLAG_POS]}, 32'h1);
    // measure sources and routing
    wr(L1, 8'h20);
    wr(U1, 8'h20);
    pulse(1'b1);
    check({30'h0, irq6_o, irq5_o}, 32'h2);
    rd(U1);
    check(d, 32'h30);
    wr(U1, 8'h20);
    pulse(1'b0);
    check({30'h0, irq6_o, irq5_o}, 32'h1);
    wr(PM, 8'h10);
    pulse(1'b1);
    check({31'h0, irq6_o}, 32'h0);
    wr(PM, 8'h00);
    // upper one-shot drives its own output bit
    wr(UD, 8'h02);
    wr(U1, 8'ha0);
    repeat (10) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check({31'h0, upper_out_o}, 32'h1);
    rd(U1);
    check(d, 32'h24);
    // a write without the low byte strobe is ignored
    pstrb_i <= 4'he;
    wr(L0, 8'h00);
    pstrb_i <= 4'hf;
    rd(L0);
    check(d, 32'h83);
    report_and_stop();
  end
endmodule
`default_nettype wire
